//--- src/l1_power_pkg.sv
// Package for the L1 bank power and core clock gating block
package l1_power_pkg;
   localparam int NUM_BANKS = 4;
   localparam int CLK_MHZ = 100;
   localparam int WAKE_CYCLES_DOC = 11;
   localparam int WAKE_CYCLES = WAKE_CYCLES_DOC;
   localparam int WAKE_CNT_W = 4;
   localparam logic [7:0] OFS_SLEEP_CTL = 8'h00;
   localparam logic [7:0] OFS_SHUTDOWN_CTL = 8'h04;
   localparam logic [7:0] OFS_SYS_CTL = 8'h08;
   localparam logic [7:0] OFS_GLOBAL_CTL = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int SYS_SD_EN_BIT = 0;
   localparam int SYS_GATE_DIS_BIT = 1;
   localparam int GLB_SLEEP_EN_BIT = 0;
   localparam logic [3:0] BANK_CTL_RST = 4'h0;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   typedef struct packed {
      logic shutdown_feature_enable;
      logic core_clock_gating_disable;
      logic core_light_sleep_enable;
   } power_ctl_t;

   typedef struct packed {
      logic hsel;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] haddr;
      logic hready;
   } ahb_req_t;

   typedef enum logic [1:0] {CORE_RUN, CORE_GATED} core_state_t;
endpackage

//--- src/l1_bank_power_and_core_gating.sv
// L1 bank sleep/shutdown control and core clock gating
`timescale 1ns/1ps
// Operation
// - Each of four banks has its own sleep bit; one sleeps, zero wakes.
// - All sleep bits reset to zero; no bank sleeps after reset.
// - Bank leaving sleep needs eleven cycles, counted from clearing its bit.
// - Accesses before sleep wake completes read zero and drop writes.
// - Lowest quarter megabyte of bank zero always stays powered.
// - Separate per-bank shutdown control; more saving, contents lost.
// - Shutdown acts only while system-control shutdown-enable bit is one.
// - Bank leaving shutdown needs eleven cycles before it is usable.
// - With light-sleep enable set, core clocks gate while idle.
// - Gating-disable bit set prevents core clock gating during idle.
// - Gating starts at execute stage two; memory and DMA ports stay clocked.
// - Core timer stops while core clocks are gated.
// - Event controller interrupt ends gating and restores core clocks.
// - Debug wake request also ends light sleep.
module l1_bank_power_and_core_gating
   import l1_power_pkg::*;
#(
   parameter int BANKS = NUM_BANKS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic idle_at_execute_stage_two,
   input wire logic system_event_controller_irq,
   input wire logic debug_wake_request,
   input wire logic [BANKS-1:0] bank_access_req,
   input wire logic bank_zero_low_region,
   output logic [BANKS-1:0] bank_sleep_out,
   output logic [BANKS-1:0] bank_shutdown_out,
   output logic [BANKS-1:0] bank_ready,
   output logic [BANKS-1:0] bank_access_grant,
   output logic core_clock_enable,
   output logic core_timer_enable,
   output logic port_clock_enable
);
   initial begin
      if (BANKS != NUM_BANKS) begin
         $error("Only four banks are supported");
      end
      // The wake counter must hold the full latency
      if (WAKE_CYCLES >= (1 << WAKE_CNT_W)) begin
         $error("Wake counter too narrow");
      end
   end

   logic rst_meta_reg, rst_sync_reg;
   logic rst_i;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_i = rst_sync_reg;

   // Wake inputs come from other domains; three stages, change on agreement
   logic [2:0] irq_sh_reg, irq_sh_next;
   logic [2:0] dbg_sh_reg, dbg_sh_next;
   logic irq_lvl_reg, irq_lvl_next;
   logic dbg_lvl_reg, dbg_lvl_next;

   // Register state
   logic [3:0] sleep_ctl_reg, sleep_ctl_next;
   logic [3:0] shutdown_ctl_reg, shutdown_ctl_next;
   power_ctl_t ctl_reg, ctl_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] wr_addr_reg, wr_addr_next;

   // Bank state
   logic [WAKE_CNT_W-1:0] slp_cnt_reg [BANKS];
   logic [WAKE_CNT_W-1:0] slp_cnt_next [BANKS];
   logic [WAKE_CNT_W-1:0] sd_cnt_reg [BANKS];
   logic [WAKE_CNT_W-1:0] sd_cnt_next [BANKS];
   logic [BANKS-1:0] sleep_out_reg, sleep_out_next;
   logic [BANKS-1:0] sd_out_reg, sd_out_next;
   logic [BANKS-1:0] ready_reg, ready_next;
   logic [BANKS-1:0] grant_reg, grant_next;

   // Core gating state
   core_state_t core_state_reg, core_state_next;
   logic core_en_reg, core_en_next;

   function automatic logic [WAKE_CNT_W-1:0] wake_step(
      input logic asleep,
      input logic [WAKE_CNT_W-1:0] cnt
   );
      logic [WAKE_CNT_W-1:0] r;
      r = cnt;
      if (asleep) begin
         r = WAKE_CNT_W'(WAKE_CYCLES);
      end else if (cnt != '0) begin
         r = cnt - 1'b1;
      end
      return r;
   endfunction

   logic [3:0] sd_eff;
   logic addr_phase;

   always_comb begin
      irq_sh_next = {irq_sh_reg[1:0], system_event_controller_irq};
      dbg_sh_next = {dbg_sh_reg[1:0], debug_wake_request};
      irq_lvl_next = irq_lvl_reg;
      dbg_lvl_next = dbg_lvl_reg;
      if (irq_sh_reg[1] == irq_sh_reg[2]) begin
         irq_lvl_next = irq_sh_reg[2];
      end
      if (dbg_sh_reg[1] == dbg_sh_reg[2]) begin
         dbg_lvl_next = dbg_sh_reg[2];
      end
   end

   always_comb begin
      addr_phase = hsel && hready && htrans[1];
      sleep_ctl_next = sleep_ctl_reg;
      shutdown_ctl_next = shutdown_ctl_reg;
      ctl_next = ctl_reg;
      hrdata_next = hrdata_reg;
      wr_pend_next = 1'b0;
      wr_addr_next = wr_addr_reg;
      if (wr_pend_reg) begin
         unique case (wr_addr_reg)
            OFS_SLEEP_CTL: sleep_ctl_next = hwdata[3:0];
            OFS_SHUTDOWN_CTL: shutdown_ctl_next = hwdata[3:0];
            OFS_SYS_CTL: begin
               ctl_next.shutdown_feature_enable = hwdata[SYS_SD_EN_BIT];
               ctl_next.core_clock_gating_disable =
                  hwdata[SYS_GATE_DIS_BIT];
            end
            OFS_GLOBAL_CTL:
               ctl_next.core_light_sleep_enable = hwdata[GLB_SLEEP_EN_BIT];
            default: ;
         endcase
      end
      if (addr_phase) begin
         wr_pend_next = hwrite;
         wr_addr_next = haddr[7:0];
         hrdata_next = ZERO_WORD;
         if (!hwrite) begin
            unique case (haddr[7:0])
               OFS_SLEEP_CTL: hrdata_next = {28'h0, sleep_ctl_reg};
               OFS_SHUTDOWN_CTL: hrdata_next = {28'h0, shutdown_ctl_reg};
               OFS_SYS_CTL: hrdata_next = {30'h0,
                  ctl_reg.core_clock_gating_disable,
                  ctl_reg.shutdown_feature_enable};
               OFS_GLOBAL_CTL:
                  hrdata_next = {31'h0, ctl_reg.core_light_sleep_enable};
               OFS_STATUS: hrdata_next = {23'h0, core_en_reg, ready_reg,
                  sd_out_reg};
               default: hrdata_next = ZERO_WORD;
            endcase
         end
      end
   end

   // Shutdown request counts only with the feature enabled
   assign sd_eff = shutdown_ctl_reg & {4{ctl_reg.shutdown_feature_enable}};

   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         slp_cnt_next[b] = wake_step(sleep_ctl_reg[b], slp_cnt_reg[b]);
         sd_cnt_next[b] = wake_step(sd_eff[b], sd_cnt_reg[b]);
      end
      sleep_out_next = sleep_ctl_reg;
      sd_out_next = sd_eff;
      for (int b = 0; b < BANKS; b++) begin
         // Counters kept apart so one mode's wake never shortens the other
         ready_next[b] = !sleep_ctl_reg[b] && !sd_eff[b] &&
            slp_cnt_next[b] == '0 && sd_cnt_next[b] == '0;
      end
      // Ungranted accesses read zero and drop writes in the bank wrapper
      grant_next = bank_access_req & ready_next;
      if (bank_access_req[0] && bank_zero_low_region) begin
         grant_next[0] = 1'b1;
      end
   end

   always_comb begin
      core_state_next = core_state_reg;
      unique case (core_state_reg)
         CORE_RUN: begin
            if (idle_at_execute_stage_two &&
                ctl_reg.core_light_sleep_enable &&
                !ctl_reg.core_clock_gating_disable &&
                !irq_lvl_reg && !dbg_lvl_reg) begin
               core_state_next = CORE_GATED;
            end
         end
         CORE_GATED: begin
            if (irq_lvl_reg || dbg_lvl_reg ||
                ctl_reg.core_clock_gating_disable) begin
               core_state_next = CORE_RUN;
            end
         end
      endcase
      core_en_next = core_state_next == CORE_RUN;
   end

   // Wake input synchronisers
   always_ff @(posedge ref_clk or negedge rst_i) begin
      if (!rst_i) begin
         irq_sh_reg <= 3'h0;
         dbg_sh_reg <= 3'h0;
         irq_lvl_reg <= 1'b0;
         dbg_lvl_reg <= 1'b0;
      end else begin
         irq_sh_reg <= irq_sh_next;
         dbg_sh_reg <= dbg_sh_next;
         irq_lvl_reg <= irq_lvl_next;
         dbg_lvl_reg <= dbg_lvl_next;
      end
   end

   // Register file and bus data phase
   always_ff @(posedge ref_clk or negedge rst_i) begin
      if (!rst_i) begin
         sleep_ctl_reg <= BANK_CTL_RST;
         shutdown_ctl_reg <= BANK_CTL_RST;
         ctl_reg <= '0;
         hrdata_reg <= ZERO_WORD;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         sleep_ctl_reg <= sleep_ctl_next;
         shutdown_ctl_reg <= shutdown_ctl_next;
         ctl_reg <= ctl_next;
         hrdata_reg <= hrdata_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
      end
   end

   // Bank wake counters and outputs
   always_ff @(posedge ref_clk or negedge rst_i) begin
      if (!rst_i) begin
         for (int b = 0; b < BANKS; b++) begin
            slp_cnt_reg[b] <= '0;
            sd_cnt_reg[b] <= '0;
         end
         sleep_out_reg <= '0;
         sd_out_reg <= '0;
         ready_reg <= '1;
         grant_reg <= '0;
      end else begin
         slp_cnt_reg <= slp_cnt_next;
         sd_cnt_reg <= sd_cnt_next;
         sleep_out_reg <= sleep_out_next;
         sd_out_reg <= sd_out_next;
         ready_reg <= ready_next;
         grant_reg <= grant_next;
      end
   end

   // Core gating state
   always_ff @(posedge ref_clk or negedge rst_i) begin
      if (!rst_i) begin
         core_state_reg <= CORE_RUN;
         core_en_reg <= 1'b1;
      end else begin
         core_state_reg <= core_state_next;
         core_en_reg <= core_en_next;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign bank_sleep_out = sleep_out_reg;
   assign bank_shutdown_out = sd_out_reg;
   assign bank_ready = ready_reg;
   assign bank_access_grant = grant_reg;
   assign core_clock_enable = core_en_reg;
   assign core_timer_enable = core_en_reg;
   // Memory interface and DMA ports gated only until the synchronised reset releases
   assign port_clock_enable = rst_sync_reg;
endmodule

//--- verif/l1_power_properties.sv
// Port checker for bank power and core clock gating
`timescale 1ns/1ps
module l1_power_properties #(
   parameter int BANKS = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic idle_at_execute_stage_two,
   input wire logic system_event_controller_irq,
   input wire logic debug_wake_request,
   input wire logic [BANKS-1:0] bank_access_req,
   input wire logic [BANKS-1:0] bank_sleep_out,
   input wire logic [BANKS-1:0] bank_ready,
   input wire logic [BANKS-1:0] bank_access_grant,
   input wire logic core_clock_enable,
   input wire logic core_timer_enable,
   input wire logic port_clock_enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or answered with an error");
   a_grant_req: assert property ((bank_access_grant & ~$past(bank_access_req)) == '0)
      else $error("grant without a request");
   a_grant_ready: assert property ((bank_access_grant[BANKS-1:1] & ~bank_ready[BANKS-1:1]) == '0)
      else $error("grant to a bank that was not ready");
   // Sleep copy lags its bit by one stage, so ready may rise nine after it
   a_wake_late: assert property ((bank_ready & ~$past(bank_ready) & $past(bank_sleep_out, 9)) == '0)
      else $error("bank ready too soon after sleep");
   a_gate_idle: assert property ($fell(core_clock_enable) |-> $past(idle_at_execute_stage_two))
      else $error("core clock gated without idle");
   a_timer_stop: assert property (core_timer_enable == core_clock_enable)
      else $error("core timer not following core clock");
   a_port_live: assert property (!core_clock_enable |-> port_clock_enable)
      else $error("port clock stopped while core gated");
   a_port_hold: assert property (port_clock_enable |=> port_clock_enable)
      else $error("port clock dropped");
   a_wake_soon: assert property ((system_event_controller_irq || debug_wake_request) && !core_clock_enable |-> ##[1:8] core_clock_enable)
      else $error("core clock not restored on wake event");
endmodule

//--- verif/l1_bank_power_and_core_gating_test.sv
// Self-checking bench for bank power and core clock gating
`timescale 1ns/1ps
module l1_bank_power_and_core_gating_test;
   import l1_power_pkg::*;
   logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, idle = 0, irq = 0;
   logic dbg = 0, low = 0, hreadyout, hresp, cke, tke, pke;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, r;
   logic [3:0] req = 0, slp, sdo, rdy, gnt;
   logic [31:0] m [4] = '{default: 0};
   logic [31:0] mask [4] = '{32'hf, 32'hf, 32'h3, 32'h1};
   int error_cnt = 0, checks_done = 0, seed = 32'hfa54, n;
   l1_bank_power_and_core_gating l1_bank_power_and_core_gating_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .idle_at_execute_stage_two(idle),
      .system_event_controller_irq(irq), .debug_wake_request(dbg),
      .bank_access_req(req), .bank_zero_low_region(low),
      .bank_sleep_out(slp), .bank_shutdown_out(sdo), .bank_ready(rdy),
      .bank_access_grant(gnt), .core_clock_enable(cke),
      .core_timer_enable(tke), .port_clock_enable(pke));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait on the slave's ready; a hang ends the run
   task automatic waitrdy;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (hreadyout === 1'b1) break;
      end
      if (n == 20) begin
         chk(32'h0, 32'h1);
         report_and_stop();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      waitrdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitrdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      if (a < 8'h10) m[a[3:2]] = d & mask[a[3:2]];
   endtask
   // Status packs core enable, bank ready and effective shutdown
   task automatic rdchk(input logic [7:0] a);
      logic [3:0] e;
      e = m[1][3:0] & {4{m[2][0]}};
      bus(1'b0, a, 32'h0);
      if (a == OFS_STATUS) chk(rd, {23'h0, 1'b1, ~(m[0][3:0] | e), e});
      else chk(rd, a < 8'h10 ? m[a[3:2]] : 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int a = 0; a < 24; a += 4) rdchk(a[7:0]);
      chk({28'h0, rdy}, 32'hf);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         wr(OFS_SYS_CTL, {30'h0, r[9:8]});
         wr(OFS_SLEEP_CTL, {28'h0, r[3:0]});
         wr(OFS_SHUTDOWN_CTL, {28'h0, r[7:4] & ~r[3:0]});
         wr(8'h14, r);
         repeat (16) @(posedge ref_clk);
         for (int a = 0; a < 24; a += 4) rdchk(a[7:0]);
         chk({28'h0, slp}, m[0]);
         chk({28'h0, sdo}, m[1] & {32{m[2][0]}});
      end
      wr(OFS_SLEEP_CTL, 32'h0);
      wr(OFS_SHUTDOWN_CTL, 32'h0);
      wr(OFS_SYS_CTL, 32'h1);
      req <= 4'hf;
      $display("register traffic done");
      for (int md = 0; md < 2; md++) for (int k = 0; k < 4; k++) begin
         wr(md ? OFS_SHUTDOWN_CTL : OFS_SLEEP_CTL, 32'h1 << k);
         repeat (16) @(posedge ref_clk);
         chk({28'h0, rdy}, {28'h0, 4'(~(4'h1 << k))});
         chk({28'h0, gnt}, {28'h0, 4'(~(4'h1 << k))});
         if (k == 0) begin
            low <= 1'b1;
            repeat (3) @(posedge ref_clk);
            chk({31'h0, gnt[0]}, 32'h1);
            low <= 1'b0;
         end
         wr(md ? OFS_SHUTDOWN_CTL : OFS_SLEEP_CTL, 32'h0);
         for (n = 0; n < 30 && rdy[k] !== 1'b1; n++) @(posedge ref_clk);
         chk({31'h0, n >= 10 && n <= 15}, 32'h1);
      end
      $display("bank wake done");
      wr(OFS_GLOBAL_CTL, 32'h1);
      for (int s = 0; s < 3; s++) begin
         if (s == 2) wr(OFS_SYS_CTL, 32'h3);
         idle <= 1'b1;
         repeat (4) @(posedge ref_clk);
         chk({31'h0, cke}, {31'h0, s == 2});
         chk({31'h0, tke}, {31'h0, s == 2});
         chk({31'h0, pke}, 32'h1);
         irq <= s == 0;
         dbg <= s == 1;
         for (n = 0; n < 12 && cke !== 1'b1; n++) @(posedge ref_clk);
         chk({31'h0, cke}, 32'h1);
         idle <= 1'b0;
         irq <= 1'b0;
         dbg <= 1'b0;
         repeat (8) @(posedge ref_clk);
      end
      $display("core gating done");
      report_and_stop();
   end
endmodule
bind l1_bank_power_and_core_gating l1_power_properties #(.BANKS(BANKS))
   l1_power_properties_i (.ref_clk(ref_clk), .rst_n(rst_n),
   .hreadyout(hreadyout), .hresp(hresp),
   .idle_at_execute_stage_two(idle_at_execute_stage_two),
   .system_event_controller_irq(system_event_controller_irq),
   .debug_wake_request(debug_wake_request),
   .bank_access_req(bank_access_req), .bank_sleep_out(bank_sleep_out),
   .bank_ready(bank_ready), .bank_access_grant(bank_access_grant),
   .core_clock_enable(core_clock_enable),
   .core_timer_enable(core_timer_enable),
   .port_clock_enable(port_clock_enable));
